// ===== design/fmh_pkg.sv
// Package: constants and carrier types for the flash module host controller
//
// Overview of operation
// - Host drives bank select as address LSB on reads and on writes alike.
// - Host drives chip select low to select; edges select and deselect.
// - Mode decode: read, output disable, write from select, enable, strobe.
// - Array changes only after complete command sequence, never one write.
// - Command sequences start with AA to 5555 then 55 to 2AAA.
`default_nettype none

package fmh_pkg;

    // =========================================================
    // Register map (Avalon word addresses)
    localparam logic [2:0] REG_CTRL   = 3'h0;
    localparam logic [2:0] REG_ADDR   = 3'h1;
    localparam logic [2:0] REG_WDATA  = 3'h2;
    localparam logic [2:0] REG_RDATA  = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h4;

    // CTRL fields: writing starts an operation
    localparam int CTRL_OP_LSB   = 0;    // 2-bit opcode
    localparam int CTRL_BANK_BIT = 2;    // bank_half_select value
    localparam int CTRL_ID_BIT   = 3;    // raise id_elevated_level request
    localparam int CTRL_UNLK_BIT = 4;    // prefix unlock writes

    // STATUS fields
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;

    // =========================================================
    // Opcodes
    localparam logic [1:0] OP_READ  = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;

    // =========================================================
    // Unlock sequence
    localparam logic [14:0] UNLOCK_ADDR1 = 15'h5555;
    localparam logic [14:0] UNLOCK_ADDR2 = 15'h2AAA;
    localparam logic [15:0] UNLOCK_DATA1 = 16'h00AA;
    localparam logic [15:0] UNLOCK_DATA2 = 16'h0055;

    // =========================================================
    // Timing
    localparam int CLK_PERIOD_NS  = 20;
    localparam int ACCESS_NS      = 200;  // slowest read access time
    localparam int STROBE_NS      = 100;  // write strobe low width
    localparam int RECOVER_NS     = 40;   // idle between bus cycles
    localparam int ACCESS_CYC  = (ACCESS_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int STROBE_CYC  = (STROBE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int RECOVER_CYC = (RECOVER_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
    localparam int CNT_W = 4;

    // =========================================================
    // Carrier types
    typedef struct packed {
        logic        chip_sel_n;
        logic        out_en_n;
        logic        write_strobe_lo_n;
        logic        write_strobe_hi_n;
        logic        bank_half_select;
        logic        id_elevated_level;
        logic [19:0] address_lines;
    } fmh_ctl_s;

    typedef enum logic [2:0] {
        ST_IDLE, ST_SETUP, ST_STROBE, ST_HOLD, ST_RECOVER
    } fmh_state_e;

endpackage : fmh_pkg

`default_nettype wire

// ===== design/fmh_host.sv
// Host controller driving the flash module pins from Avalon-MM registers
`default_nettype none

module fmh_host
    import fmh_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        clk_en,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    output var fmh_ctl_s     pins,
    input  wire logic [15:0] data_in,
    output logic      [15:0] data_out,
    output logic             data_oe
);

    // =========================================================
    // Registers
    fmh_state_e        state;
    logic [CNT_W-1:0]  cnt;
    logic [19:0]       addr_reg;
    logic [15:0]       wdata_reg;
    logic [15:0]       rdata_reg;
    logic [1:0]        op_reg;
    logic              bank_reg;
    logic              id_reg;
    logic [1:0]        unlock_left;
    logic              done;
    logic              rd_pend;
    logic [CNT_W-1:0]  oe_low_cnt;
    fmh_ctl_s          next_pins;

    // =========================================================
    // Bus decode
    wire busy      = (state != ST_IDLE);
    wire wr_ctrl   = avs_write && avs_address == REG_CTRL;
    wire wr_addr   = avs_write && avs_address == REG_ADDR;
    wire wr_wdata  = avs_write && avs_address == REG_WDATA;
    wire start     = wr_ctrl && !busy && clk_en;
    wire is_read   = (op_reg == OP_READ) && (unlock_left == 2'h0);
    wire cnt_zero  = (cnt == '0);
    wire cyc_last  = cnt_zero && state == ST_RECOVER;

    // Reads take one wait state so that read data comes from a flop
    wire rd_load   = avs_read && !rd_pend;

    // Stall a register write that would disturb a running cycle
    assign avs_waitrequest = (avs_write && busy &&
                              avs_address != REG_STATUS) || rd_load
                             || !clk_en;

    wire [31:0] rd_ctrl = {27'h0, 1'b0, id_reg, bank_reg, op_reg};
    wire [31:0] rd_stat = {30'h0, done, busy};
    wire [31:0] rd_mux  =
        (avs_address == REG_CTRL)   ? rd_ctrl :
        (avs_address == REG_ADDR)   ? {12'h0, addr_reg} :
        (avs_address == REG_WDATA)  ? {16'h0, wdata_reg} :
        (avs_address == REG_RDATA)  ? {16'h0, rdata_reg} :
        (avs_address == REG_STATUS) ? rd_stat : 32'h0;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            avs_readdata <= 32'h0;
            rd_pend      <= 1'b0;
        end else if (clk_en) begin
            // Data stands through the accepting edge of the read
            rd_pend <= rd_load;
            if (rd_load) avs_readdata <= rd_mux;
        end
    end

    // =========================================================
    // Cycle address and data: unlock writes come first
    // Unlock prefix is two writes; the command write comes from ADDR and WDATA
    wire [19:0] cur_addr =
        (unlock_left == 2'h2) ? {addr_reg[19:15], UNLOCK_ADDR1} :
        (unlock_left == 2'h1) ? {addr_reg[19:15], UNLOCK_ADDR2} : addr_reg;
    wire [15:0] cur_data =
        (unlock_left == 2'h2) ? UNLOCK_DATA1 :
        (unlock_left == 2'h1) ? UNLOCK_DATA2 : wdata_reg;

    // =========================================================
    // Sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state       <= ST_IDLE;
            cnt         <= '0;
            addr_reg    <= 20'h0;
            wdata_reg   <= 16'h0;
            rdata_reg   <= 16'h0;
            op_reg      <= OP_READ;
            bank_reg    <= 1'b0;
            id_reg      <= 1'b0;
            unlock_left <= 2'h0;
            done        <= 1'b0;
        end else if (clk_en) begin
            if (wr_addr && !busy) addr_reg <= avs_writedata[19:0];
            if (wr_wdata && !busy) wdata_reg <= avs_writedata[15:0];
            unique case (state)
                ST_IDLE: begin
                    if (start) begin
                        op_reg      <= avs_writedata[CTRL_OP_LSB +: 2];
                        bank_reg    <= avs_writedata[CTRL_BANK_BIT];
                        id_reg      <= avs_writedata[CTRL_ID_BIT];
                        unlock_left <= avs_writedata[CTRL_UNLK_BIT]
                                       ? 2'h2 : 2'h0;
                        done        <= 1'b0;
                        cnt         <= CNT_W'(RECOVER_CYC - 1);
                        state       <= ST_SETUP;
                    end
                end
                ST_SETUP: begin
                    if (cnt_zero) begin
                        cnt   <= is_read ? CNT_W'(ACCESS_CYC - 1)
                                         : CNT_W'(STROBE_CYC - 1);
                        state <= ST_STROBE;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_STROBE: begin
                    if (cnt_zero) begin
                        state <= ST_HOLD;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                ST_HOLD: begin
                    // Sample read data
                    // Pins lag state by a cycle, so wait out the full access
                    if (is_read) rdata_reg <= data_in;
                    cnt   <= CNT_W'(RECOVER_CYC - 1);
                    state <= ST_RECOVER;
                end
                ST_RECOVER: begin
                    if (!cnt_zero) begin
                        cnt <= cnt - 1'b1;
                    end else if (unlock_left != 2'h0) begin
                        unlock_left <= unlock_left - 1'b1;
                        cnt         <= CNT_W'(RECOVER_CYC - 1);
                        state       <= ST_SETUP;
                    end else begin
                        done  <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // =========================================================
    // Pin drive
    wire active  = (state == ST_SETUP) || (state == ST_STROBE)
                   || (state == ST_HOLD);
    wire strobe  = (state == ST_STROBE);
    wire in_wr   = active && !is_read;

    always_comb begin
        next_pins = '{chip_sel_n: 1'b1, out_en_n: 1'b1,
                      write_strobe_lo_n: 1'b1, write_strobe_hi_n: 1'b1,
                      bank_half_select: 1'b0, id_elevated_level: 1'b0,
                      address_lines: 20'h0};
        next_pins.chip_sel_n = !active;
        next_pins.address_lines = cur_addr;
        next_pins.bank_half_select = bank_reg;
        next_pins.id_elevated_level = id_reg && is_read && active;
        // Read decode: enable low, strobe high
        next_pins.out_en_n = !(strobe && is_read);
        // Write strobes pulse only in writes
        next_pins.write_strobe_lo_n = !(strobe && !is_read);
        next_pins.write_strobe_hi_n = !(strobe && !is_read);
    end

    // Registered pins keep strobes glitch free at the module boundary
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pins     <= '{chip_sel_n: 1'b1, out_en_n: 1'b1,
                          write_strobe_lo_n: 1'b1, write_strobe_hi_n: 1'b1,
                          bank_half_select: 1'b0, id_elevated_level: 1'b0,
                          address_lines: 20'h0};
            data_out <= 16'h0;
            data_oe  <= 1'b0;
        end else if (clk_en) begin
            pins     <= next_pins;
            // Drive command or data during writes
            data_out <= cur_data;
            data_oe  <= in_wr;
        end
    end

    // =========================================================
    // Assertions
    // Output-enable low time, to check the read access window
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            oe_low_cnt <= '0;
        end else if (clk_en) begin
            oe_low_cnt <= pins.out_en_n ? '0 : oe_low_cnt + 1'b1;
        end
    end

    wire rd_sample = (state == ST_HOLD) && is_read && clk_en;

    property p_access;
        @(posedge clk) disable iff (sys_rst)
        rd_sample |-> !pins.out_en_n && !pins.chip_sel_n
                      && oe_low_cnt >= CNT_W'(ACCESS_CYC - 1);
    endproperty
    a_access: assert property (p_access)
        else $error("Read data sampled before access time");

    property p_id_read;
        @(posedge clk) disable iff (sys_rst)
        pins.id_elevated_level |-> pins.write_strobe_lo_n
                                   && pins.write_strobe_hi_n;
    endproperty
    a_id_read: assert property (p_id_read)
        else $error("Identifier level raised during a write");

    property p_cs_gap;
        @(posedge clk) disable iff (sys_rst)
        $rose(pins.chip_sel_n) |=> pins.chip_sel_n;
    endproperty
    a_cs_gap: assert property (p_cs_gap)
        else $error("Chip select high for a single cycle only");

    property p_no_contend;
        @(posedge clk) disable iff (sys_rst)
        data_oe |-> pins.out_en_n;
    endproperty
    a_no_contend: assert property (p_no_contend)
        else $error("Data driven while output enable low");

    property p_excl;
        @(posedge clk) disable iff (sys_rst)
        !(pins.out_en_n == 1'b0 && pins.write_strobe_lo_n == 1'b0);
    endproperty
    a_excl: assert property (p_excl)
        else $error("Output enable and write strobe low together");

    property p_sel;
        @(posedge clk) disable iff (sys_rst)
        (!pins.out_en_n || !pins.write_strobe_lo_n) |-> !pins.chip_sel_n;
    endproperty
    a_sel: assert property (p_sel)
        else $error("Strobe active without chip select");

    property p_wr_data;
        @(posedge clk) disable iff (sys_rst)
        !pins.write_strobe_lo_n |-> data_oe;
    endproperty
    a_wr_data: assert property (p_wr_data)
        else $error("Write strobe without data drive");

    property p_unlock1;
        @(posedge clk) disable iff (sys_rst)
        ($fell(pins.write_strobe_lo_n) && unlock_left == 2'h2)
            |-> pins.address_lines[14:0] == UNLOCK_ADDR1
                && data_out == UNLOCK_DATA1;
    endproperty
    a_unlock1: assert property (p_unlock1)
        else $error("First unlock write wrong");

    property p_unlock2;
        @(posedge clk) disable iff (sys_rst)
        ($fell(pins.write_strobe_lo_n) && unlock_left == 2'h1)
            |-> pins.address_lines[14:0] == UNLOCK_ADDR2
                && data_out == UNLOCK_DATA2;
    endproperty
    a_unlock2: assert property (p_unlock2)
        else $error("Second unlock write wrong");

    property p_addr_stable;
        @(posedge clk) disable iff (sys_rst)
        (!pins.write_strobe_lo_n && clk_en && $past(clk_en))
            |-> $stable(pins.address_lines);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("Address moved during write strobe");

    property p_data_hold;
        @(posedge clk) disable iff (sys_rst)
        (clk_en && $rose(pins.write_strobe_lo_n)) |-> data_oe;
    endproperty
    a_data_hold: assert property (p_data_hold)
        else $error("Data released before strobe rise");

    property p_bank;
        @(posedge clk) disable iff (sys_rst)
        !pins.out_en_n |-> pins.bank_half_select == bank_reg;
    endproperty
    a_bank: assert property (p_bank)
        else $error("Bank select not steady in read");

    c_read:   cover property (@(posedge clk) $fell(pins.out_en_n));
    c_write:  cover property (@(posedge clk) $fell(pins.write_strobe_lo_n));
    c_unlock: cover property (@(posedge clk)
                  unlock_left == 2'h1 && !pins.write_strobe_lo_n);
    c_id:     cover property (@(posedge clk) pins.id_elevated_level);
    c_rdwait: cover property (@(posedge clk) rd_load && clk_en);

endmodule : fmh_host

`default_nettype wire

// ===== dv/fmh_flash_model.sv
// Pin-level behavioural model of the flash module
`default_nettype none

module fmh_flash_model
    import fmh_pkg::*;
#(
    parameter int          DELAY_NS = 180,
    parameter logic [15:0] MFG_CODE = 16'h005A, // Arbitrary value
    parameter logic [15:0] DEV_CODE = 16'h00B3  // Arbitrary value
)(
    input  var fmh_ctl_s     pins,
    input  wire logic [15:0] data_out,
    input  wire logic        data_oe,
    output logic      [15:0] data_in,
    output logic             dev_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem [logic [20:0]];
    logic [20:0] key, wa;
    logic [15:0] rd_val;
    logic        rd_mode, rd_late, wr_n;
    int          step = 0;
    // =========================================================
    // Mode decode
    // either strobe writes
    assign wr_n = pins.write_strobe_lo_n & pins.write_strobe_hi_n;
    assign rd_mode = !pins.chip_sel_n & !pins.out_en_n & wr_n;
    // Slow access: wrong data shows until the delay runs out
    assign #(DELAY_NS) rd_late = rd_mode;
    assign key = {pins.address_lines, pins.bank_half_select};
    // array by default, codes at elevated level with address bit 1 low
    always @* begin
        if (pins.id_elevated_level && !pins.address_lines[1])
            rd_val = pins.address_lines[0] ? DEV_CODE : MFG_CODE;
        else if (mem.exists(key))
            rd_val = mem[key];
        else
            rd_val = key[16:1] ^ 16'h5AC3 ^ {15'h0, key[0]};
    end
    // float unless reading; float shows inverted value
    assign dev_drive = rd_mode;
    always @* begin
        if (data_oe)
            data_in = data_out;
        else if (rd_mode)
            data_in = rd_late ? rd_val : ~rd_val;
        else
            data_in = ~rd_val;
    end
    // =========================================================
    // Writes
    // address taken on strobe fall
    always @(negedge wr_n) if (!pins.chip_sel_n) wa = key;
    // data on strobe rise, array only after unlock
    always @(posedge wr_n) if (!pins.chip_sel_n) begin
        if (step == 3)
            mem[wa] = data_in;
        if (step == 0 && wa[15:1] == UNLOCK_ADDR1 && data_in[7:0] == 8'hAA)
            step = 1;
        else if (step == 1 && wa[15:1] == UNLOCK_ADDR2
                 && data_in[7:0] == 8'h55)
            step = 2;
        else if (step == 2 && wa[15:1] == UNLOCK_ADDR1
                 && data_in[7:0] == 8'hA0)
            step = 3;
        else
            step = 0;
    end
endmodule : fmh_flash_model

`default_nettype wire

// ===== dv/testbench.sv
// Self-checking bench for the flash module host controller
`default_nettype none

module testbench;
    import fmh_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, sys_rst, clk_en, avs_read, avs_write;
    logic        avs_waitrequest, data_oe, dev_drive;
    logic [2:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [15:0] data_in, data_out;
    fmh_ctl_s    pins;
    int          err_count = 0;
    int          checks = 0;

    fmh_host dut (.clk(clk), .sys_rst(sys_rst), .clk_en(clk_en),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .pins(pins), .data_in(data_in), .data_out(data_out),
        .data_oe(data_oe));
    fmh_flash_model flash (.pins(pins), .data_out(data_out),
        .data_oe(data_oe), .data_in(data_in), .dev_drive(dev_drive));

    // =========================================================
    // Helpers
    task automatic summarize();
        if (err_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] e, g);
        checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic bus(input logic rd, input logic [2:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_read <= rd;
        avs_write <= !rd;
        // Waitrequest at the falling edge is what the next rise samples
        do begin
            @(negedge clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 400);
        if (n >= 400) begin
            err_count++;
            summarize();
        end
        // Accepting edge: read data stands here and is taken now
        @(posedge clk);
        r = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    task automatic do_op(input logic [19:0] a, input logic [15:0] d,
                         input logic [4:0] ctrl);
        int n;
        n = 0;
        bus(1'b0, REG_ADDR, {12'h0, a}, q);
        bus(1'b0, REG_WDATA, {16'h0, d}, q);
        bus(1'b0, REG_CTRL, {27'h0, ctrl}, q);
        do begin
            bus(1'b1, REG_STATUS, 32'h0, q);
            n++;
        end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 200);
        if (n >= 200) begin
            err_count++;
            summarize();
        end
        chk("done", 32'h1, {31'h0, q[STAT_DONE_BIT]});
    endtask : do_op

    function automatic logic [15:0] init_w(logic [19:0] a, logic b);
        return a[15:0] ^ 16'h5AC3 ^ {15'h0, b};
    endfunction : init_w

    // =========================================================
    // Pin monitors
    always @(negedge clk) if (!sys_rst) begin
        chk("contention", 32'h0, {31'h0, dev_drive & data_oe});
        chk("write_mode", 32'h0, {31'h0, !(pins.write_strobe_lo_n
            & pins.write_strobe_hi_n) & (!pins.out_en_n | !data_oe
            | pins.chip_sel_n)});
    end

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    // =========================================================
    // Scenarios
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 3'h0;
        avs_writedata = 32'h0;
        repeat (4) @(posedge clk);
        sys_rst <= 1'b0;
        @(negedge clk);
        chk("idle_pins", 32'h1E, {27'h0, pins.chip_sel_n, pins.out_en_n,
            pins.write_strobe_lo_n, pins.write_strobe_hi_n, data_oe});
        for (int b = 0; b < 2; b++) begin
            do_op(20'hF0F0F, 16'h0, {2'h0, b[0], OP_READ});
            bus(1'b1, REG_RDATA, 32'h0, q);
            chk("array_read", {16'h0, init_w(20'hF0F0F, b[0])},
                q);
        end
        for (int i = 0; i < 2; i++) begin
            do_op(20'(i), 16'h0, {2'h1, 1'b0, OP_READ});
            bus(1'b1, REG_RDATA, 32'h0, q);
            chk("id_code", {16'h0, i ? 16'h00B3 : 16'h005A}, q);
        end
        do_op(20'h00777, 16'h1111, {3'h0, OP_WRITE});
        do_op(20'h00777, 16'h0, {3'h0, OP_READ});
        bus(1'b1, REG_RDATA, 32'h0, q);
        chk("single_write", {16'h0, init_w(20'h00777, 1'b0)}, q);
        do_op(20'h05555, 16'h00A0, {3'h4, OP_WRITE});
        do_op(20'h12340, 16'hBEEF, {3'h0, OP_WRITE});
        for (int b = 0; b < 2; b++) begin
            do_op(20'h12340, 16'h0, {2'h0, b[0], OP_READ});
            bus(1'b1, REG_RDATA, 32'h0, q);
            chk("program", {16'h0, b ? init_w(20'h12340, 1'b1)
                : 16'hBEEF}, q);
        end
        bus(1'b1, 3'h7, 32'h0, q);
        chk("unmapped", 32'h0, q);
        @(posedge clk);
        clk_en <= 1'b0;
        @(negedge clk);
        chk("frozen", 32'h3, {30'h0, avs_waitrequest,
            pins.chip_sel_n});
        @(posedge clk);
        clk_en <= 1'b1;
        summarize();
    end
endmodule : testbench

`default_nettype wire
